//--- hw/lcmrc_pkg.sv
// Constants, types and register map of the light curtain muting and restart control
`default_nettype none
package lcmrc_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ        = 25_000_000;  // System clock rate
  localparam int unsigned MS_PER_S      = 1000;        // Milliseconds in a second
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;  // Cycles in one millisecond
  localparam int unsigned TW            = 24;          // Width of millisecond timers
  localparam real         SIMUL_WIN_S   = 0.5;         // Sensor simultaneity window, seconds
  localparam int unsigned MUTE_MAX_MIN  = 10;          // Longest muting episode, minutes
  localparam logic [TW-1:0] SIMUL_WIN_MS = TW'(int'(SIMUL_WIN_S * 1000.0));
  localparam logic [TW-1:0] MUTE_MAX_MS  = TW'(MUTE_MAX_MIN * 60 * MS_PER_S);

  // Fieldbus station address
  localparam int unsigned  STA_W        = 8;
  localparam logic [STA_W-1:0] STATION_RST = 8'h21;   // Own station address after reset

  // Process image layout
  localparam int unsigned IMG_W         = 32;
  localparam int unsigned IN_GUARD      = 0;   // Guard output status, 1 = guard output on
  localparam int unsigned IN_MUTE       = 8;   // Muting active flag
  localparam int unsigned IN_SENS1      = 10;  // Muting sensor 1 busy
  localparam int unsigned IN_SENS2      = 11;  // Muting sensor 2 busy
  localparam int unsigned IN_LOCAL      = 14;  // Local button, 0 = operated
  localparam int unsigned IN_LOCK       = 15;  // Restart interlock active
  localparam int unsigned OUT_SELF_CHECK = 1;  // Self-check request
  localparam int unsigned OUT_PERMIT    = 9;   // Override permit
  localparam int unsigned OUT_RESTART   = 14;  // Remote restart request

  // Register byte offsets
  localparam int unsigned AW            = 8;
  localparam logic [AW-1:0] REG_CTRL     = 8'h00;
  localparam logic [AW-1:0] REG_SIMUL    = 8'h04;
  localparam logic [AW-1:0] REG_MUTE     = 8'h08;
  localparam logic [AW-1:0] REG_STATION  = 8'h0c;
  localparam logic [AW-1:0] REG_ZONE     = 8'h10;
  localparam logic [AW-1:0] REG_STATUS   = 8'h14;
  localparam logic [AW-1:0] REG_IRQ_STAT = 8'h18;
  localparam logic [AW-1:0] REG_IRQ_MASK = 8'h1c;

  // Control register fields
  localparam int unsigned CTRL_MANUAL   = 0;
  localparam int unsigned CTRL_TOTAL    = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h3;
  localparam logic [31:0] ZONE_RST      = 32'h0000_0000;

  // Event bits of status and mask registers
  localparam int unsigned EV_BREAK      = 0;
  localparam int unsigned EV_TIMEOUT    = 1;
  localparam int unsigned EV_LATE       = 2;
  localparam int unsigned EV_RESTART    = 3;
  localparam int unsigned EV_OVRD       = 4;
  localparam int unsigned EV_W          = 5;

  // Bus constants
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  // Control states
  typedef enum logic [2:0] {
    ST_LOCK  = 3'b000,
    ST_RUN   = 3'b001,
    ST_WAIT2 = 3'b010,
    ST_MUTE  = 3'b011,
    ST_OVRD  = 3'b100,
    ST_FAULT = 3'b101
  } lcmrc_state_t;

  // Software configuration
  typedef struct packed {
    logic            manual;
    logic            total;
    logic [TW-1:0]   simul_ms;
    logic [TW-1:0]   mute_ms;
    logic [STA_W-1:0] station;
    logic [31:0]     zone;
  } lcmrc_cfg_t;

  // Commands from the controller's output image
  typedef struct packed {
    logic permit;
    logic restart;
    logic self_check;
  } lcmrc_cmd_t;
endpackage
`default_nettype wire

//--- hw/lcmrc_sync.sv
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module lcmrc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;  // First stage, read only by the second
  logic [W-1:0] sync_q;  // Second stage

  // Two stages in series
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

//--- hw/lcmrc_tick.sv
// Millisecond tick generator
`default_nettype none
module lcmrc_tick #(
  parameter int unsigned CYC = lcmrc_pkg::MS_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  localparam int unsigned CW = (CYC > 1) ? $clog2(CYC) : 1;  // Counter width
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);              // Final count

  logic [CW-1:0] cnt_q;  // Cycle counter
  logic [CW-1:0] cnt_d;
  logic          tick_q; // One-cycle pulse
  logic          tick_d;

  // Next count and pulse
  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
  end

  // Register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule
`default_nettype wire

//--- hw/lcmrc_top.sv
// Light curtain restart interlock, muting sequencer, image exchange and register slave
`default_nettype none
module lcmrc_top #(
  parameter int unsigned NBEAMS    = 16,
  parameter int unsigned MS_CYCLES = lcmrc_pkg::MS_CYCLES
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          hsel_i,
  input  wire logic [31:0]                   haddr_i,
  input  wire logic [1:0]                    htrans_i,
  input  wire logic                          hwrite_i,
  input  wire logic [2:0]                    hsize_i,
  input  wire logic [31:0]                   hwdata_i,
  input  wire logic                          hready_i,
  output logic                               hreadyout_o,
  output logic                               hresp_o,
  output logic [31:0]                        hrdata_o,
  input  wire logic [NBEAMS-1:0]             beams_clear_i,
  input  wire logic [1:0]                    mute_sensor_i,
  input  wire logic                          local_button_n_i,
  input  wire logic                          image_valid_i,
  input  wire logic [lcmrc_pkg::STA_W-1:0]   image_addr_i,
  input  wire logic [lcmrc_pkg::IMG_W-1:0]   output_image_i,
  output logic      [lcmrc_pkg::IMG_W-1:0]   input_image_o,
  output logic                               safety_switch_output_o,
  output logic                               irq_o
);
  import lcmrc_pkg::*;

  // Synchronised pins
  logic [NBEAMS-1:0] beams_s;     // 1 = beam clear
  logic [1:0]        sens_s;      // 1 = sensor busy
  logic              btn_s;       // 1 = local button operated; reset 0 reads as released
  logic              tick;        // Millisecond pulse

  lcmrc_sync #(.W(NBEAMS + 3)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({beams_clear_i, mute_sensor_i, ~local_button_n_i}),
    .sync_o    ({beams_s, sens_s, btn_s})
  );

  lcmrc_tick #(.CYC(MS_CYCLES)) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick)
  );

  // Register state
  lcmrc_cfg_t    cfg_q, cfg_d;        // Configuration
  logic [EV_W-1:0] stat_q, stat_d;    // Sticky events
  logic [EV_W-1:0] mask_q, mask_d;    // Interrupt mask
  logic          wr_q, wr_d;          // Write pending in data phase
  logic [AW-1:0] addr_q, addr_d;      // Data phase address
  logic [31:0]   rdata_q, rdata_d;    // Read data
  // Control state
  lcmrc_state_t  st_q, st_d;          // Sequencer state
  logic [TW-1:0] simul_q, simul_d;    // Simultaneity timer, ms
  logic [TW-1:0] mute_q, mute_d;      // Muting duration timer, ms
  logic [IMG_W-1:0] img_q, img_d;     // Accepted output image
  logic [IMG_W-1:0] in_img_q, in_img_d;  // Input image to controller
  logic          guard_q, guard_d;    // Guard output
  logic [2:0]    prev_q, prev_d;      // Previous request levels
  // Combinational helpers
  lcmrc_cmd_t    cmd;                 // Commands from image
  logic [EV_W-1:0] ev;                // Events this cycle
  logic [NBEAMS-1:0] mute_mask;       // Beams ignored now
  logic          raw_clear;           // All beams clear
  logic          muted_clear;         // Unmasked beams clear
  logic          sens_any, sens_both; // Sensor states
  logic          local_press;         // Local button operated
  logic          rst_rise, chk_rise, loc_rise;  // Request edges
  logic          ovr_req;             // Override request
  logic          ap;                  // Address phase taken
  logic          muting_now;          // Muted state

  // Read decode
  function automatic logic [31:0] rd_mux(input logic [AW-1:0] a, input lcmrc_cfg_t c,
                                         input logic [EV_W-1:0] s, input logic [EV_W-1:0] m,
                                         input logic [7:0] sts);
    logic [31:0] r;
    r = '0;
    case (a)
      REG_CTRL:     r = {30'h0, c.total, c.manual};
      REG_SIMUL:    r = {{(32-TW){1'b0}}, c.simul_ms};
      REG_MUTE:     r = {{(32-TW){1'b0}}, c.mute_ms};
      REG_STATION:  r = {{(32-STA_W){1'b0}}, c.station};
      REG_ZONE:     r = c.zone;
      REG_STATUS:   r = {24'h0, sts};
      REG_IRQ_STAT: r = {{(32-EV_W){1'b0}}, s};
      REG_IRQ_MASK: r = {{(32-EV_W){1'b0}}, m};
      default:      r = '0;          // Unmapped reads zero
    endcase
    return r;
  endfunction

  // Field evaluation and request edges
  always_comb begin
    cmd.permit     = img_q[OUT_PERMIT];
    cmd.restart    = img_q[OUT_RESTART];
    cmd.self_check = img_q[OUT_SELF_CHECK];
    muting_now  = (st_q == ST_MUTE) || (st_q == ST_OVRD);
    mute_mask   = muting_now ? (cfg_q.total ? '1 : cfg_q.zone[NBEAMS-1:0]) : '0;
    raw_clear   = &beams_s;
    muted_clear = &(beams_s | mute_mask);
    sens_any    = |sens_s;
    sens_both   = &sens_s;
    local_press = btn_s;
    loc_rise    = local_press & ~prev_q[0];
    rst_rise    = (cmd.restart & ~prev_q[1]) | loc_rise;
    chk_rise    = cmd.self_check & ~prev_q[2];
    ovr_req     = cmd.permit & (loc_rise | rst_rise | chk_rise);
  end

  // Sequencer next state
  always_comb begin
    st_d    = st_q;
    simul_d = simul_q;
    mute_d  = mute_q;
    ev      = '0;
    prev_d  = {cmd.self_check, cmd.restart, local_press};
    case (st_q)
      ST_LOCK, ST_FAULT: begin
        if (ovr_req && sens_any) begin        // Override of blocked muting
          st_d = ST_OVRD;
          mute_d = '0;
          ev[EV_OVRD] = 1'b1;
        end else if (!raw_clear) begin
          if (st_q == ST_FAULT) begin         // Normal evaluation after late sensor
            st_d = ST_LOCK;
            ev[EV_BREAK] = 1'b1;
          end
        end else if (st_q == ST_FAULT) begin
          if (!sens_any) begin
            st_d = ST_RUN;
          end
        end else if (!cfg_q.manual || rst_rise) begin
          st_d = ST_RUN;
          ev[EV_RESTART] = 1'b1;
        end
      end
      ST_RUN: begin
        if (!raw_clear) begin                 // Beam break
          st_d = ST_LOCK;
          ev[EV_BREAK] = 1'b1;
        end else if (sens_both) begin
          st_d = ST_MUTE;
          mute_d = '0;
        end else if (sens_any) begin          // First sensor starts window
          st_d = ST_WAIT2;
          simul_d = '0;
        end
      end
      ST_WAIT2: begin
        if (!raw_clear) begin
          st_d = ST_LOCK;
          ev[EV_BREAK] = 1'b1;
        end else if (!sens_any) begin
          st_d = ST_RUN;
        end else if (simul_q > cfg_q.simul_ms) begin  // Window expired
          st_d = ST_FAULT;
          ev[EV_LATE] = 1'b1;
        end else if (sens_both) begin
          st_d = ST_MUTE;
          mute_d = '0;
        end else if (tick) begin
          simul_d = simul_q + TW'(1);
        end
      end
      ST_MUTE, ST_OVRD: begin
        if (mute_q >= cfg_q.mute_ms) begin    // Duration limit
          st_d = raw_clear ? ST_RUN : ST_LOCK;
          ev[EV_TIMEOUT] = 1'b1;
        end else if (!sens_any || (st_q == ST_OVRD && !cmd.permit)) begin
          st_d = raw_clear ? ST_RUN : ST_LOCK;
        end else if (!muted_clear) begin      // Break outside muted beams
          st_d = ST_LOCK;
          ev[EV_BREAK] = 1'b1;
        end else if (tick) begin
          mute_d = mute_q + TW'(1);
        end
      end
      default: begin
        st_d = ST_LOCK;
      end
    endcase
    // Image accepted only when addressed to this station
    img_d = (image_valid_i && image_addr_i == cfg_q.station) ? output_image_i : img_q;
    guard_d = (st_d != ST_LOCK) && !img_d[OUT_SELF_CHECK];
    in_img_d = '0;
    in_img_d[IN_GUARD] = guard_d;
    in_img_d[IN_MUTE]  = (st_d == ST_MUTE) || (st_d == ST_OVRD);
    in_img_d[IN_SENS1] = sens_s[0];
    in_img_d[IN_SENS2] = sens_s[1];
    in_img_d[IN_LOCAL] = ~btn_s;
    in_img_d[IN_LOCK]  = (st_d == ST_LOCK);
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q     <= ST_LOCK;
      simul_q  <= '0;
      mute_q   <= '0;
      img_q    <= '0;
      in_img_q <= '0;
      guard_q  <= 1'b0;
      prev_q   <= '0;
    end else begin
      st_q     <= st_d;
      simul_q  <= simul_d;
      mute_q   <= mute_d;
      img_q    <= img_d;
      in_img_q <= in_img_d;
      guard_q  <= guard_d;
      prev_q   <= prev_d;
    end
  end

  // Bus slave next state
  always_comb begin
    ap      = hsel_i && hready_i && htrans_i[1];
    wr_d    = ap && hwrite_i && (hsize_i == HSIZE_WORD);
    addr_d  = ap ? haddr_i[AW-1:0] : addr_q;
    rdata_d = (ap && !hwrite_i) ?
              rd_mux(haddr_i[AW-1:0], cfg_q, stat_q, mask_q,
                     {2'b00, st_q, cmd.permit, muting_now, guard_q}) : rdata_q;
    cfg_d   = cfg_q;
    mask_d  = mask_q;
    stat_d  = stat_q | ev;                   // Set wins over clear
    if (wr_q) begin
      case (addr_q)
        REG_CTRL: begin
          cfg_d.manual = hwdata_i[CTRL_MANUAL];
          cfg_d.total  = hwdata_i[CTRL_TOTAL];
        end
        REG_SIMUL:    cfg_d.simul_ms = hwdata_i[TW-1:0];
        REG_MUTE:     cfg_d.mute_ms  = hwdata_i[TW-1:0];
        REG_STATION:  cfg_d.station  = hwdata_i[STA_W-1:0];
        REG_ZONE:     cfg_d.zone     = hwdata_i;
        REG_IRQ_STAT: stat_d = (stat_q & ~hwdata_i[EV_W-1:0]) | ev;
        REG_IRQ_MASK: mask_d = hwdata_i[EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Bus slave registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q   <= '{manual: CTRL_RST[CTRL_MANUAL], total: CTRL_RST[CTRL_TOTAL],
                   simul_ms: SIMUL_WIN_MS, mute_ms: MUTE_MAX_MS,
                   station: STATION_RST, zone: ZONE_RST};
      stat_q  <= '0;
      mask_q  <= '0;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      rdata_q <= '0;
    end else begin
      cfg_q   <= cfg_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign hreadyout_o            = 1'b1;
  assign hresp_o                = 1'b0;
  assign hrdata_o               = rdata_q;
  assign input_image_o          = in_img_q;
  assign safety_switch_output_o = guard_q;
  assign irq_o                  = |(stat_q & mask_q);

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_LOCK_GUARD_OFF: assert property (st_q == ST_LOCK |-> !guard_q)
    else $error("guard on while interlocked");
  AST_MANUAL_HOLD: assert property (
    (st_q == ST_LOCK && cfg_q.manual && !rst_rise) |=> st_q != ST_RUN)
    else $error("manual restart released without request");
  AST_TOTAL_MASK: assert property (
    (st_q == ST_MUTE && cfg_q.total && sens_any && mute_q < cfg_q.mute_ms) |=> st_q == ST_MUTE)
    else $error("total muting left beams evaluated");
  AST_LATE_NO_MUTE: assert property (
    (st_q == ST_WAIT2 && simul_q > cfg_q.simul_ms) |=> st_q != ST_MUTE)
    else $error("muting entered after window");
  AST_LATE_FAULT: assert property (
    (st_q == ST_WAIT2 && raw_clear && sens_any && simul_q > cfg_q.simul_ms)
    |=> st_q == ST_FAULT && in_img_q[IN_MUTE] == 1'b0)
    else $error("late sensor not rejected");
  AST_MUTE_LIMIT: assert property (
    (muting_now && mute_q >= cfg_q.mute_ms) |=> !in_img_q[IN_MUTE] && !muting_now)
    else $error("muting beyond limit");
  AST_TIMEOUT_BROKEN: assert property (
    (muting_now && mute_q >= cfg_q.mute_ms && !raw_clear)
    |=> st_q == ST_LOCK && !safety_switch_output_o)
    else $error("expiry with broken field kept guard on");
  AST_GUARD_BIT: assert property (in_img_q[IN_GUARD] |-> st_q != ST_LOCK && guard_q)
    else $error("guard status bit wrong");
  AST_RESTART_BIT: assert property (
    (st_q == ST_LOCK && cfg_q.manual && rst_rise && raw_clear && !(ovr_req && sens_any))
    |=> st_q == ST_RUN && in_img_q[IN_LOCK] == 1'b0)
    else $error("restart request ignored");
  AST_OVRD_PERMIT: assert property ($rose(st_q == ST_OVRD) |-> $past(cmd.permit))
    else $error("override without permit");
  AST_PERMIT_DROP: assert property ((st_q == ST_OVRD && !cmd.permit) |=> st_q != ST_OVRD)
    else $error("override kept after permit drop");
  AST_STATION: assert property (
    $changed(img_q) |-> $past(image_valid_i && image_addr_i == cfg_q.station))
    else $error("image taken at foreign address");
  AST_MUTE_FLAG: assert property (in_img_q[IN_MUTE] == muting_now)
    else $error("muting flag mismatch");
  AST_SELF_CHECK: assert property (img_q[OUT_SELF_CHECK] |-> !guard_q && !in_img_q[IN_GUARD])
    else $error("guard on during self-check");

  COV_MUTE: cover property (st_q == ST_WAIT2 ##1 st_q == ST_MUTE);
  COV_TIMEOUT: cover property (muting_now && mute_q >= cfg_q.mute_ms);
  COV_LATE: cover property (st_q == ST_WAIT2 ##1 st_q == ST_FAULT);
  COV_OVRD: cover property ($rose(st_q == ST_OVRD));
endmodule
`default_nettype wire

//--- testbench/lcmrc_ctl_model.sv
// Behavioural safety controller that writes the device's output image
`default_nettype none
module lcmrc_ctl_model (
  input  wire logic        sys_clk_i,
  output logic             image_valid_o,
  output logic [7:0]       image_addr_o,
  output logic [31:0]      output_image_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    image_valid_o  = 1'b0;
    image_addr_o   = 8'h00;
    output_image_o = 32'h0000_0000;
  end
  // One word per call: restart, override permit and self-check bits
  task automatic send(input logic [7:0] a, input logic r, input logic p, input logic s);
    logic [31:0] w;
    w     = $urandom & 32'hffff_bdfd;  // Unused bits carry noise
    w[14] = r;
    w[9]  = p;
    w[1]  = s;
    @(posedge sys_clk_i);
    image_valid_o  <= 1'b1;
    image_addr_o   <= a;
    output_image_o <= w;
    @(posedge sys_clk_i);
    // Released word is inverted so a stale value never looks fresh
    image_valid_o  <= 1'b0;
    image_addr_o   <= ~a;
    output_image_o <= ~w;
  endtask
endmodule
`default_nettype wire

//--- testbench/lcmrc_tb_top.sv
// Self-checking bench for the light curtain restart and muting control
`default_nettype none
module lcmrc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lcmrc_pkg::*;
  logic        sys_clk_i = 1'b0;  // 25 MHz system clock
  logic        rst_n_i   = 1'b0;  // Active low reset
  logic        hsel, hwrite, hready, hresp, valid, sso, irq, btn_n;
  logic [31:0] haddr, hwdata, hrdata, img_out, img_in, q;
  logic [1:0]  htrans, sens;
  logic [2:0]  hsize;
  logic [7:0]  iaddr;
  logic [15:0] beams;
  int          n_fail    = 0;     // Mismatches
  int          tests_run = 0;     // Comparisons
  int          exp_guard, exp_mute; // Reference model of guard and muting outputs

  // Clock generator
  always #20 sys_clk_i = ~sys_clk_i;

  lcmrc_top #(.MS_CYCLES(10)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .beams_clear_i(beams), .mute_sensor_i(sens), .local_button_n_i(btn_n),
    .image_valid_i(valid), .image_addr_i(iaddr), .output_image_i(img_out),
    .input_image_o(img_in), .safety_switch_output_o(sso), .irq_o(irq));

  lcmrc_ctl_model u_ctl (
    .sys_clk_i(sys_clk_i), .image_valid_o(valid), .image_addr_o(iaddr),
    .output_image_o(img_out));

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One AHB single word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // Read a register and compare with its expected value
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, q);
    chk("hresp", 0, hresp);
  endtask

  // Let pin synchronisers and the state machine settle
  task automatic settle();
    repeat (6) @(posedge sys_clk_i);
  endtask

  // Compare guard pin, guard image bit and muting flag with the model
  task automatic look();
    chk("guard_pin", exp_guard, sso);
    chk("guard_bit", exp_guard, img_in[IN_GUARD]);
    chk("mute_bit", exp_mute, img_in[IN_MUTE]);
  endtask

  // Rising restart request from the controller
  task automatic restart();
    u_ctl.send(STATION_RST, 1'b0, 1'b0, 1'b0);
    u_ctl.send(STATION_RST, 1'b1, 1'b0, 1'b0);
    settle();
  endtask

  // Print counts and verdict, then end the run
  task automatic report_and_stop();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    beams     = 16'hffff;
    sens      = 2'h0;
    btn_n     = 1'b1;
    exp_guard = 0;
    exp_mute  = 0;
    void'($urandom(4));
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // Reset values and an unmapped place
    rdchk(REG_CTRL, 32'(CTRL_RST));
    rdchk(REG_STATION, 32'(STATION_RST));
    rdchk(REG_SIMUL, 32'(SIMUL_WIN_MS));
    rdchk(REG_MUTE, 32'(MUTE_MAX_MS));
    rdchk(8'h40, 32'h0);
    bus(1'b1, REG_SIMUL, 32'h3);
    bus(1'b1, REG_MUTE, 32'h14);
    bus(1'b1, REG_IRQ_MASK, 32'h1 << EV_TIMEOUT);
    rdchk(REG_MUTE, 32'h14);
    settle();
    look();
    chk("lock_bit", 1, img_in[IN_LOCK]);
    chk("local_bit", 1, img_in[IN_LOCAL]);
    // Restart at another station is ignored
    u_ctl.send(8'h20, 1'b0, 1'b0, 1'b0);
    u_ctl.send(8'h20, 1'b1, 1'b0, 1'b0);
    settle();
    look();
    restart();
    exp_guard = 1;
    look();
    u_ctl.send(STATION_RST, 1'b1, 1'b0, 1'b1);
    exp_guard = 0;
    settle();
    look();
    u_ctl.send(STATION_RST, 1'b1, 1'b0, 1'b0);
    exp_guard = 1;
    settle();
    look();
    // Beam break locks until clear and a fresh request
    beams <= ~(16'h1 << ($urandom % 16));
    exp_guard = 0;
    settle();
    look();
    beams <= 16'hffff;
    settle();
    look();
    restart();
    exp_guard = 1;
    look();
    // Sensors inside the window mute the whole field
    sens <= 2'h1;
    repeat (10) @(posedge sys_clk_i);
    sens <= 2'h3;
    exp_mute = 1;
    settle();
    look();
    chk("sensor_bits", 3, img_in[IN_SENS2:IN_SENS1]);
    beams <= 16'h0000;
    settle();
    look();
    repeat (100) @(posedge sys_clk_i);
    look();
    repeat (150) @(posedge sys_clk_i);
    exp_guard = 0;
    exp_mute  = 0;
    look();
    chk("irq", 1, irq);
    bus(1'b1, REG_IRQ_STAT, 32'hffff_ffff);
    settle();
    chk("irq", 0, irq);
    // Override refused without permit, entered with it
    btn_n <= 1'b0;
    settle();
    btn_n <= 1'b1;
    bus(1'b0, REG_STATUS, 32'h0);
    chk("state", 0, q[5:3]);
    u_ctl.send(STATION_RST, 1'b0, 1'b1, 1'b0);
    btn_n <= 1'b0;
    settle();
    btn_n <= 1'b1;
    bus(1'b0, REG_STATUS, 32'h0);
    chk("state", 4, q[5:3]);
    u_ctl.send(STATION_RST, 1'b0, 1'b0, 1'b0);
    settle();
    bus(1'b0, REG_STATUS, 32'h0);
    chk("state", 0, q[5:3]);
    // Late second sensor keeps normal evaluation
    sens  <= 2'h0;
    beams <= 16'hffff;
    settle();
    restart();
    exp_guard = 1;
    sens <= 2'h2;
    repeat (80) @(posedge sys_clk_i);
    sens <= 2'h3;
    settle();
    look();
    beams <= 16'h7fff;
    exp_guard = 0;
    settle();
    look();
    // Automatic restart leaves the interlock as soon as the field clears
    bus(1'b1, REG_CTRL, 32'h2);
    sens  <= 2'h0;
    beams <= 16'hffff;
    exp_guard = 1;
    settle();
    look();
    report_and_stop();
  end
endmodule
`default_nettype wire
